/* cap_sense_params.svh */
// What this block does
// - Multi-channel enable shorts scanned channels together
// - Gain 1x to 8x, resets to 8x
// - Gain from three-bit field in mode register
// - Touch comparator event wakes device from suspend, only while unit enable bit set
// - Aux wake with mode 101b wakes on scan end
// - Aux wake with mode 110b/111b wakes per conversion
// - With accumulation, wake only after all samples
// - Wake behaviour bit selects wake conditions used
`ifndef CAP_SENSE_PARAMS_SVH
`define CAP_SENSE_PARAMS_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define OFS_MODE 8'h00
`define OFS_MODE2 8'h04
`define OFS_SCAN 8'h08
`define OFS_STATUS 8'h0C
`define OFS_MASK 8'h10
`define OFS_ACCUM 8'h14

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define MODE_GAIN_LSB 0
`define MODE_CM_LSB 4
`define MODE_EN_BIT 7
`define MODE2_MCEN_BIT 0
`define MODE2_AUXW_BIT 1
`define MODE2_WOI_BIT 2

// ------------------------------------------------------------
// Reset values and codes
// ------------------------------------------------------------
`define GAIN_RESET 3'h7
`define CM_SCAN_END 3'h5
`define CM_CONV_A 3'h6
`define CM_CONV_B 3'h7
`define NUM_CH 16

`endif

/* cap_sense_pkg.sv */
package cap_sense_pkg;
  // Events from the conversion engine
  typedef struct packed {
    logic touch;
    logic scan_done;
    logic conv_done;
  } cs_event_t;

  // AHB-Lite request captured in address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } ahb_req_t;
endpackage

/* cap_sense_channel_gain_wake.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cap_sense_params.svh"

module cap_sense_channel_gain_wake
  import cap_sense_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Conversion engine events
  input wire cs_event_t eng_event,
  // Analog front end control
  output logic [15:0] channel_short,
  output logic multi_channel_active,
  output logic [3:0] gain_factor,
  output logic unit_enable,
  output logic [2:0] start_mode_out,
  // Power management and interrupt
  output logic wake_req,
  output logic irq
);

  // ----------------------------------------------------------
  // Registers
  // ----------------------------------------------------------
  logic [7:0] mode_reg;
  logic [2:0] mode2_reg;
  logic [15:0] scan_reg;
  logic [3:0] accum_reg;
  logic [2:0] status_reg;
  logic [2:0] status_next;
  logic [2:0] mask_reg;
  logic [3:0] acc_cnt_reg;
  logic [31:0] rdata_reg;
  logic wake_reg;
  ahb_req_t req_reg;

  logic [2:0] gain_select;
  logic [2:0] start_mode_select;
  logic auxiliary_wake_enable;
  logic wake_behaviour_select;
  logic multi_channel_enable;
  logic acc_full;
  logic conv_wake;
  logic scan_wake;
  logic wake_now;
  logic rd_status;

  assign gain_select = mode_reg[`MODE_GAIN_LSB +: 3];
  assign start_mode_select = mode_reg[`MODE_CM_LSB +: 3];
  assign multi_channel_enable = mode2_reg[`MODE2_MCEN_BIT];
  assign auxiliary_wake_enable = mode2_reg[`MODE2_AUXW_BIT];
  assign wake_behaviour_select = mode2_reg[`MODE2_WOI_BIT];

  // ----------------------------------------------------------
  // AHB-Lite slave, zero wait states, always OKAY
  // ----------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_reg;

  // Capture address phase
  always_ff @(posedge core_clk) begin
    if (rst) begin
      req_reg <= '0;
    end else if (hready) begin
      req_reg.valid <= hsel & htrans[1];
      req_reg.write <= hwrite;
      req_reg.addr <= haddr[7:0];
    end
  end

  // Software-written configuration
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode_reg <= {5'h00, `GAIN_RESET};
      mode2_reg <= 3'h0;
      scan_reg <= 16'h0000;
      accum_reg <= 4'h0;
      mask_reg <= 3'h0;
    end else if (req_reg.valid && req_reg.write) begin
      case (req_reg.addr)
        `OFS_MODE: mode_reg <= hwdata[7:0];
        `OFS_MODE2: mode2_reg <= hwdata[2:0];
        `OFS_SCAN: scan_reg <= hwdata[15:0];
        `OFS_ACCUM: accum_reg <= hwdata[3:0];
        `OFS_MASK: mask_reg <= hwdata[2:0];
        default: ;
      endcase
    end
  end

  // Read data is presented in the data phase, so decode the address
  // phase directly; size is ignored since only words are served
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_reg <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        `OFS_MODE: rdata_reg <= {24'h000000, mode_reg};
        `OFS_MODE2: rdata_reg <= {29'h0, mode2_reg};
        `OFS_SCAN: rdata_reg <= {16'h0000, scan_reg};
        // Report the bits held before this read clears them; an event in
        // the same cycle stays set and shows up on the next read
        `OFS_STATUS: rdata_reg <= {29'h0, status_reg};
        `OFS_MASK: rdata_reg <= {29'h0, mask_reg};
        `OFS_ACCUM: rdata_reg <= {28'h0, accum_reg};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign rd_status = hready && hsel && htrans[1] && !hwrite &&
                     (haddr[7:0] == `OFS_STATUS);

  // ----------------------------------------------------------
  // Channel combining and gain
  // ----------------------------------------------------------
  // Short every scanned channel onto one node only in multi mode
  always_ff @(posedge core_clk) begin
    if (rst) begin
      channel_short <= 16'h0000;
      multi_channel_active <= 1'b0;
    end else begin
      channel_short <= multi_channel_enable ? scan_reg : 16'h0000;
      multi_channel_active <= multi_channel_enable;
    end
  end

  // Linear map: code 0 is 1x, code 7 is 8x
  always_ff @(posedge core_clk) begin
    if (rst) begin
      gain_factor <= 4'h8;
    end else begin
      gain_factor <= {1'b0, gain_select} + 4'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      unit_enable <= 1'b0;
      start_mode_out <= 3'h0;
    end else begin
      unit_enable <= mode_reg[`MODE_EN_BIT];
      start_mode_out <= start_mode_select;
    end
  end

  // ----------------------------------------------------------
  // Sample accumulation; accum_reg holds samples minus one
  // ----------------------------------------------------------
  assign acc_full = (acc_cnt_reg == accum_reg);

  always_ff @(posedge core_clk) begin
    if (rst || !mode_reg[`MODE_EN_BIT]) begin
      acc_cnt_reg <= 4'h0;
    end else if (eng_event.conv_done) begin
      acc_cnt_reg <= acc_full ? 4'h0 : acc_cnt_reg + 4'h1;
    end
  end

  // ----------------------------------------------------------
  // Wake decision
  // ----------------------------------------------------------
  // Conversion wake counts only completed accumulations
  assign conv_wake = auxiliary_wake_enable &&
                     ((start_mode_select == `CM_CONV_A) ||
                      (start_mode_select == `CM_CONV_B)) &&
                     eng_event.conv_done && acc_full;
  assign scan_wake = auxiliary_wake_enable &&
                     (start_mode_select == `CM_SCAN_END) &&
                     eng_event.scan_done;
  // Behaviour bit low: touch only; high: touch plus aux events
  assign wake_now = eng_event.touch ||
                    (wake_behaviour_select && (conv_wake || scan_wake));

  // Disabled unit never wakes; software must leave it enabled across sleep
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= wake_now && mode_reg[`MODE_EN_BIT];
    end
  end
  assign wake_req = wake_reg;

  // ----------------------------------------------------------
  // Sticky status, cleared by read, set wins over clear
  // ----------------------------------------------------------
  always_comb begin
    status_next = status_reg;
    if (rd_status) begin
      status_next = 3'h0;
    end
    if (mode_reg[`MODE_EN_BIT]) begin
      status_next = status_next |
        {eng_event.touch, eng_event.scan_done, eng_event.conv_done};
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      status_reg <= 3'h0;
    end else begin
      status_reg <= status_next;
    end
  end

  assign irq = |(status_reg & mask_reg);

endmodule
`default_nettype wire

/* cap_sense_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module cap_sense_monitor
  import cap_sense_pkg::*;
(
  // Watched ports
  input wire logic core_clk,
  input wire logic rst,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire cs_event_t eng_event,
  input wire logic [15:0] channel_short,
  input wire logic multi_channel_active,
  input wire logic [3:0] gain_factor,
  input wire logic unit_enable,
  input wire logic wake_req
);
  // ----------------------------------------
  // Port relations
  // ----------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // A touch, with the enable seen one cycle on as the unit's own copy
  sequence touch_s;
    eng_event.touch ##1 unit_enable;
  endsequence
  // Any engine event at all
  sequence any_ev_s;
    $past(eng_event) != 3'h0;
  endsequence
  reset_gain_a: assert property ($fell(rst) |-> gain_factor == 4'h8)
    else $error("gain not 8x after reset");
  gain_range_a: assert property (gain_factor != 4'h0 && gain_factor <= 4'h8)
    else $error("gain outside 1x to 8x");
  short_gate_a: assert property (channel_short != 16'h0 |-> multi_channel_active)
    else $error("channels shorted while multi off");
  touch_wake_a: assert property (touch_s |-> wake_req)
    else $error("touch gave no wake");
  wake_cause_a: assert property (wake_req |-> any_ev_s)
    else $error("wake without an event");
  idle_quiet_a: assert property (!unit_enable ##1 !unit_enable |-> !wake_req)
    else $error("wake while unit disabled");
  ready_high_a: assert property (hreadyout)
    else $error("bus stalled");
  okay_resp_a: assert property (!hresp)
    else $error("bus error response");
endmodule
bind cap_sense_channel_gain_wake cap_sense_monitor mon_u (
  .core_clk(core_clk), .rst(rst), .hreadyout(hreadyout), .hresp(hresp),
  .eng_event(eng_event), .channel_short(channel_short),
  .multi_channel_active(multi_channel_active), .gain_factor(gain_factor),
  .unit_enable(unit_enable), .wake_req(wake_req));
`default_nettype wire

/* tb_cap_sense_channel_gain_wake.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cap_sense_params.svh"
module tb_cap_sense_channel_gain_wake
  import cap_sense_pkg::*;
;
  logic core_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2, start_mode_out;
  logic hreadyout, hresp, multi_channel_active, unit_enable, wake_req, irq;
  cs_event_t eng_event = '0;
  logic [15:0] channel_short;
  logic [3:0] gain_factor;
  int n_fail = 0, checks = 0;
  // ----------------------------------------
  // Block under test, sole bus slave
  // ----------------------------------------
  cap_sense_channel_gain_wake dut_u (.core_clk(core_clk), .rst(rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .eng_event(eng_event),
    .channel_short(channel_short),
    .multi_channel_active(multi_channel_active), .gain_factor(gain_factor),
    .unit_enable(unit_enable), .start_mode_out(start_mode_out),
    .wake_req(wake_req), .irq(irq));
  always #10 core_clk = ~core_clk;
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One single word transfer; waits on the bus's own ready
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, '0);
    chk("rdata", hrdata, exp);
  endtask
  // Pulse an engine event, then look at the wake one cycle on
  task ev(input logic [2:0] e, input logic w);
    eng_event <= e;
    @(posedge core_clk);
    eng_event <= '0;
    #1 chk("wake", {31'h0, wake_req}, {31'h0, w});
  endtask
  task t_gain;
    chk("gain", {28'h0, gain_factor}, 32'h8);
    rd(`OFS_MODE, 32'h7);
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, `OFS_MODE, 32'(i));
      @(posedge core_clk);
      #1 chk("gain", {28'h0, gain_factor}, 32'(i + 1));
    end
  endtask
  task t_multi;
    bus(1'b1, `OFS_SCAN, 32'hA5C3);
    bus(1'b1, `OFS_MODE2, 32'h1);
    @(posedge core_clk);
    #1 chk("short", {16'h0, channel_short}, 32'hA5C3);
    chk("multi", {31'h0, multi_channel_active}, 32'h1);
    bus(1'b1, `OFS_MODE2, 32'h0);
    @(posedge core_clk);
    #1 chk("short", {16'h0, channel_short}, 32'h0);
  endtask
  // Every start mode that wakes, and neighbours that must not
  task t_wake;
    bus(1'b1, `OFS_MODE, 32'hD0);
    ev(3'h4, 1'b1);
    ev(3'h2, 1'b0);
    bus(1'b1, `OFS_MODE2, 32'h4);
    ev(3'h2, 1'b0);
    bus(1'b1, `OFS_MODE2, 32'h6);
    ev(3'h2, 1'b1);
    ev(3'h1, 1'b0);
    bus(1'b1, `OFS_MODE, 32'hE0);
    ev(3'h1, 1'b1);
    bus(1'b1, `OFS_MODE, 32'hF0);
    @(posedge core_clk);
    #1 chk("smode", {29'h0, start_mode_out}, 32'h7);
    chk("enable", {31'h0, unit_enable}, 32'h1);
    ev(3'h1, 1'b1);
    bus(1'b1, `OFS_MODE, 32'h70);
    ev(3'h4, 1'b0);
  endtask
  // Three samples; only the last one may wake
  task t_accum;
    bus(1'b1, `OFS_ACCUM, 32'h2);
    bus(1'b1, `OFS_MODE, 32'hE0);
    ev(3'h1, 1'b0);
    ev(3'h1, 1'b0);
    ev(3'h1, 1'b1);
    bus(1'b1, `OFS_MODE, 32'h60);
    bus(1'b1, `OFS_MODE, 32'hE0);
  endtask
  task t_irq;
    bus(1'b0, `OFS_STATUS, '0);
    bus(1'b1, `OFS_MASK, 32'h4);
    ev(3'h4, 1'b1);
    chk("irq", {31'h0, irq}, 32'h1);
    rd(`OFS_STATUS, 32'h4);
    @(posedge core_clk);
    #1 chk("irq", {31'h0, irq}, 32'h0);
    bus(1'b1, `OFS_MASK, 32'h0);
    ev(3'h4, 1'b1);
    chk("irq", {31'h0, irq}, 32'h0);
    rd(8'h40, 32'h0);
  endtask
  task close_out;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Main sequence after five reset cycles
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1 t_gain();
    t_multi();
    t_wake();
    t_accum();
    t_irq();
    close_out();
  end
  // Hang guard, far beyond the hundred or so cycles needed
  initial begin
    #100000;
    n_fail++;
    close_out();
  end
endmodule
`default_nettype wire
